/* File: hw/lpcts_target.sv */
// Nibble bus target: cycle decode, sync generation, wait states.
// Assumes bus pins arrive asynchronously and a user side on clk_sys.
`timescale 1ns/1ps
`include "lpcts_consts.svh"

module lpcts_target #(
  parameter logic [15:0] IO_BASE = 16'h0000,
  parameter logic [15:0] IO_MASK = 16'hfff8,
  parameter logic [2:0] DMA_CHAN = 3'h0
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Bus pins
  input wire logic lclk_pin,
  input wire logic lreset_n_pin,
  input wire logic lframe_n_pin,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe,
  output logic ldrq_n,
  // Access side
  output logic acc_req,
  output logic acc_write,
  output logic acc_dma,
  output logic [15:0] acc_addr,
  output logic [2:0] acc_chan,
  output logic [7:0] acc_wdata,
  input wire logic acc_done,
  input wire logic acc_err,
  input wire logic [7:0] acc_rdata,
  input wire logic dma_req
);

  lpcts_pkg::lpcts_state_t state_reg;
  logic [6:0] pins_q;
  logic lclk_q, lrst_q, lframe_q;
  logic [3:0] lad_q;
  logic lclk_prev_reg, tick, tick_d_reg;
  logic [1:0] cnt_reg;
  logic dma_reg, wr_reg, hdata;
  logic [3:0] wait_code_reg;
  logic [15:0] addr_reg;
  logic [2:0] chan_reg;
  logic [7:0] wdata_reg, rdata_reg;
  logic [8:0] sync_cnt_reg, sync_limit;
  logic done_reg, err_reg, acc_req_reg, final_reg;
  logic [3:0] lad_out_reg, sync_code;
  logic lad_oe_reg, ldrq_n_reg;

  function automatic logic [8:0] need_waits(input logic dma, input logic wr);
    if (dma) begin
      need_waits = wr ? `LPCTS_WAIT_DMA_WR : `LPCTS_WAIT_DMA_RD;
    end else begin
      need_waits = wr ? `LPCTS_WAIT_IO_WR : `LPCTS_WAIT_IO_RD;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin capture and bus clock tick
  // ----------------------------------------------------------------------
  lpcts_pin_sync #(.WIDTH(7), .INIT(7'h1f)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({lclk_pin, lreset_n_pin, lframe_n_pin, lad_in}),
    .pin_q(pins_q)
  );

  assign {lclk_q, lrst_q, lframe_q, lad_q} = pins_q;
  assign tick = lclk_q & ~lclk_prev_reg;
  // Host drives the data nibbles on I/O write and DMA read
  assign hdata = dma_reg ? ~wr_reg : wr_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lclk_prev_reg <= 1'b1;
      tick_d_reg <= 1'b0;
    end else begin
      lclk_prev_reg <= lclk_q;
      tick_d_reg <= tick;
    end
  end

  // ----------------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || !lrst_q) begin
      state_reg <= lpcts_pkg::ST_IDLE;
      cnt_reg <= 2'h0;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (!lframe_q) begin
        cnt_reg <= 2'h0;
        state_reg <= (lad_q == `LPCTS_START) ?
          lpcts_pkg::ST_CTYPE : lpcts_pkg::ST_IDLE;
      end else begin
        unique case (state_reg)
          lpcts_pkg::ST_IDLE: begin
            cnt_reg <= 2'h0;
          end
          lpcts_pkg::ST_CTYPE: begin
            cnt_reg <= 2'h0;
            if (lad_q[3:2] == `LPCTS_CT_IO) begin
              state_reg <= lpcts_pkg::ST_ADDR;
            end else if (lad_q[3:2] == `LPCTS_CT_DMA) begin
              state_reg <= lpcts_pkg::ST_CHAN;
            end else begin
              state_reg <= lpcts_pkg::ST_IDLE;
            end
          end
          lpcts_pkg::ST_ADDR: begin
            if (cnt_reg == `LPCTS_ADDR_LAST) begin
              cnt_reg <= 2'h0;
              if ((({addr_reg[11:0], lad_q} ^ IO_BASE) & IO_MASK) != '0) begin
                state_reg <= lpcts_pkg::ST_IDLE;
              end else begin
                state_reg <= hdata ? lpcts_pkg::ST_HDATA : lpcts_pkg::ST_TAR;
              end
            end
          end
          lpcts_pkg::ST_CHAN: begin
            cnt_reg <= 2'h0;
            state_reg <= (lad_q[2:0] == DMA_CHAN) ?
              lpcts_pkg::ST_SIZE : lpcts_pkg::ST_IDLE;
          end
          lpcts_pkg::ST_SIZE: begin
            cnt_reg <= 2'h0;
            if (lad_q[1:0] != `LPCTS_SIZE_BYTE) begin
              state_reg <= lpcts_pkg::ST_IDLE;
            end else begin
              state_reg <= hdata ? lpcts_pkg::ST_HDATA : lpcts_pkg::ST_TAR;
            end
          end
          lpcts_pkg::ST_HDATA: begin
            if (cnt_reg == `LPCTS_PAIR_LAST) begin
              cnt_reg <= 2'h0;
              state_reg <= lpcts_pkg::ST_TAR;
            end
          end
          lpcts_pkg::ST_TAR: begin
            // Host owns the lines here; no timer runs while it does
            if (cnt_reg == `LPCTS_PAIR_LAST) begin
              cnt_reg <= 2'h0;
              state_reg <= lpcts_pkg::ST_SYNC;
            end
          end
          lpcts_pkg::ST_SYNC: begin
            cnt_reg <= 2'h0;
            if (final_reg) begin
              state_reg <= hdata ? lpcts_pkg::ST_TTAR :
                lpcts_pkg::ST_TDATA;
            end
          end
          lpcts_pkg::ST_TDATA: begin
            if (cnt_reg == `LPCTS_PAIR_LAST) begin
              cnt_reg <= 2'h0;
              state_reg <= lpcts_pkg::ST_TTAR;
            end
          end
          lpcts_pkg::ST_TTAR: begin
            if (cnt_reg == `LPCTS_PAIR_LAST) begin
              state_reg <= lpcts_pkg::ST_IDLE;
            end
          end
          default: begin
            state_reg <= lpcts_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Cycle fields
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dma_reg <= 1'b0;
      wr_reg <= 1'b0;
      wait_code_reg <= `LPCTS_SYNC_LONG;
      addr_reg <= 16'h0000;
      chan_reg <= 3'h0;
      wdata_reg <= 8'h00;
    end else if (tick && lframe_q) begin
      if (state_reg == lpcts_pkg::ST_CTYPE) begin
        dma_reg <= (lad_q[3:2] == `LPCTS_CT_DMA);
        wr_reg <= lad_q[1];
        wait_code_reg <= (lad_q[3:2] == `LPCTS_CT_DMA) ?
          `LPCTS_SYNC_SHORT : `LPCTS_SYNC_LONG;
      end
      if (state_reg == lpcts_pkg::ST_ADDR) begin
        addr_reg <= {addr_reg[11:0], lad_q};
      end
      if (state_reg == lpcts_pkg::ST_CHAN) begin
        chan_reg <= lad_q[2:0];
      end
      if (state_reg == lpcts_pkg::ST_HDATA) begin
        if (cnt_reg == 2'h0) begin
          wdata_reg[3:0] <= lad_q;
        end else begin
          wdata_reg[7:4] <= lad_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Access request and completion
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_req_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      acc_req_reg <= tick && lframe_q && lrst_q &&
        state_reg == lpcts_pkg::ST_TAR && cnt_reg == `LPCTS_PAIR_LAST;
      if (acc_done) begin
        done_reg <= 1'b1;
        err_reg <= acc_err;
        rdata_reg <= acc_rdata;
      end else if (tick && state_reg == lpcts_pkg::ST_TAR) begin
        done_reg <= 1'b0;
        err_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sync nibble choice and wait counting
  // ----------------------------------------------------------------------
  assign sync_limit = dma_reg ? `LPCTS_SHORT_MAX : `LPCTS_LONG_MAX;

  always_comb begin
    if (done_reg && err_reg) begin
      sync_code = `LPCTS_SYNC_ERR;
    end else if (done_reg && sync_cnt_reg >= need_waits(dma_reg, wr_reg)) begin
      sync_code = `LPCTS_SYNC_READY;
    end else if (sync_cnt_reg == sync_limit - `LPCTS_SYNC_ONE) begin
      sync_code = `LPCTS_SYNC_ERR;
    end else begin
      sync_code = wait_code_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_cnt_reg <= 9'h000;
    end else if (tick) begin
      if (state_reg == lpcts_pkg::ST_TAR) begin
        sync_cnt_reg <= 9'h000;
      end else if (state_reg == lpcts_pkg::ST_SYNC && !final_reg) begin
        sync_cnt_reg <= sync_cnt_reg + `LPCTS_SYNC_ONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || !lrst_q) begin
      lad_oe_reg <= 1'b0;
      lad_out_reg <= `LPCTS_TAR_IDLE;
      final_reg <= 1'b0;
    end else if (tick_d_reg) begin
      final_reg <= 1'b0;
      lad_oe_reg <= 1'b0;
      lad_out_reg <= `LPCTS_TAR_IDLE;
      unique case (state_reg)
        lpcts_pkg::ST_SYNC: begin
          lad_oe_reg <= 1'b1;
          lad_out_reg <= sync_code;
          final_reg <= (sync_code != wait_code_reg);
        end
        lpcts_pkg::ST_TDATA: begin
          lad_oe_reg <= 1'b1;
          lad_out_reg <= (cnt_reg == 2'h0) ? rdata_reg[3:0] : rdata_reg[7:4];
        end
        lpcts_pkg::ST_TTAR: begin
          lad_oe_reg <= (cnt_reg == 2'h0);
        end
        default: begin
          lad_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !lrst_q) begin
      ldrq_n_reg <= 1'b1;
    end else begin
      ldrq_n_reg <= ~dma_req;
    end
  end

  assign lad_out = lad_out_reg;
  assign lad_oe = lad_oe_reg;
  assign ldrq_n = ldrq_n_reg;
  assign acc_req = acc_req_reg;
  assign acc_write = wr_reg;
  assign acc_dma = dma_reg;
  assign acc_addr = addr_reg;
  assign acc_chan = chan_reg;
  assign acc_wdata = wdata_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_wait_out;
    state_reg == lpcts_pkg::ST_SYNC && lad_oe_reg && !final_reg;
  endsequence
  sequence s_final_tick;
    tick && lframe_q && lrst_q && state_reg == lpcts_pkg::ST_SYNC && final_reg;
  endsequence

  a_reset_float: assert property (!lrst_q |=> !lad_oe && ldrq_n)
    else $error("lines driven during bus reset");
  a_frame_release: assert property (tick && !lframe_q |=> ##1 !lad_oe)
    else $error("lines still driven after frame");
  a_drive_window: assert property (lad_oe |-> $past(state_reg) inside
    {lpcts_pkg::ST_SYNC, lpcts_pkg::ST_TDATA, lpcts_pkg::ST_TTAR})
    else $error("lines driven outside own phases");
  a_sync_prompt: assert property (lrst_q &&
    $rose(state_reg == lpcts_pkg::ST_SYNC) |=> lad_oe && lad_out != 4'hf)
    else $error("sync not driven at once");
  a_wait_dma: assert property (s_wait_out and dma_reg |->
    lad_out == `LPCTS_SYNC_SHORT) else $error("dma wait code wrong");
  a_wait_io: assert property (s_wait_out and !dma_reg |->
    lad_out == `LPCTS_SYNC_LONG) else $error("io wait code wrong");
  a_wait_stable: assert property (s_wait_out ##1 s_wait_out |->
    $stable(lad_out)) else $error("wait code switched");
  a_short_limit: assert property (dma_reg &&
    state_reg == lpcts_pkg::ST_SYNC |-> sync_cnt_reg < `LPCTS_SHORT_MAX)
    else $error("short wait overrun");
  a_long_limit: assert property (state_reg == lpcts_pkg::ST_SYNC
    |-> sync_cnt_reg < `LPCTS_LONG_MAX) else $error("long wait overrun");
  a_min_waits: assert property (final_reg &&
    lad_out == `LPCTS_SYNC_READY |->
    sync_cnt_reg >= need_waits(dma_reg, wr_reg))
    else $error("too few wait states");
  a_ready_data: assert property (s_final_tick and !hdata |=>
    state_reg == lpcts_pkg::ST_TDATA) else $error("data not after sync");
  a_start_only: assert property (tick && !lframe_q && lrst_q &&
    lad_q != `LPCTS_START |=> state_reg == lpcts_pkg::ST_IDLE)
    else $error("bad start accepted");
  a_ignore_other: assert property (tick && lframe_q && lrst_q &&
    state_reg == lpcts_pkg::ST_CTYPE && lad_q[3:2] != `LPCTS_CT_IO &&
    lad_q[3:2] != `LPCTS_CT_DMA |=> state_reg == lpcts_pkg::ST_IDLE)
    else $error("unsupported cycle claimed");

endmodule

/* File: hw/lpcts_consts.svh */
// Constants of the bus target: field codes, wait counts and sync limits.
// Assumes inclusion by bare name from the design files.
`ifndef LPCTS_CONSTS_SVH
`define LPCTS_CONSTS_SVH

// ----------------------------------------------------------------------
// Field codes on the nibble bus
// ----------------------------------------------------------------------
`define LPCTS_START 4'h0
`define LPCTS_CT_IO 2'h0
`define LPCTS_CT_DMA 2'h2
`define LPCTS_SIZE_BYTE 2'h0
`define LPCTS_SYNC_READY 4'h0
`define LPCTS_SYNC_SHORT 4'h5
`define LPCTS_SYNC_LONG 4'h6
`define LPCTS_SYNC_ERR 4'ha
`define LPCTS_TAR_IDLE 4'hf

// ----------------------------------------------------------------------
// Nibble counts and wait states
// ----------------------------------------------------------------------
`define LPCTS_ADDR_LAST 2'h3
`define LPCTS_PAIR_LAST 2'h1
`define LPCTS_WAIT_IO_RD 9'h003
`define LPCTS_WAIT_IO_WR 9'h002
`define LPCTS_WAIT_DMA_RD 9'h003
`define LPCTS_WAIT_DMA_WR 9'h004
`define LPCTS_SHORT_MAX 9'h008
`define LPCTS_LONG_MAX 9'h14a
`define LPCTS_SYNC_ONE 9'h001

`endif

/* File: hw/lpcts_pkg.sv */
// Types shared by the bus target.
// Assumes the constants header is on the include path.
package lpcts_pkg;

  // ----------------------------------------------------------------------
  // Cycle sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_CTYPE = 10'h002,
    ST_ADDR  = 10'h004,
    ST_CHAN  = 10'h008,
    ST_SIZE  = 10'h010,
    ST_HDATA = 10'h020,
    ST_TAR   = 10'h040,
    ST_SYNC  = 10'h080,
    ST_TDATA = 10'h100,
    ST_TTAR  = 10'h200
  } lpcts_state_t;

endpackage

/* File: hw/lpcts_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes every bit arrives from outside the clk_sys domain.
`timescale 1ns/1ps

module lpcts_pin_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_q
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] q_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("lpcts_pin_sync: WIDTH must be at least 1");
    end
  end

  // ----------------------------------------------------------------------
  // Stages; a bit changes once stages two and three agree
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_reg <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign pin_q = q_reg;

endmodule

/* File: sim/lpcts_host_model.sv */
// Behavioural host controller that runs cycles on the nibble bus.
// Assumes clk_sys at 40 MHz; the bus clock is clk_sys divided by eight.
`timescale 1ns/1ps

module lpcts_host_model (
  // System
  input wire logic clk_sys,
  // Target drive
  input wire logic [3:0] lad_out,
  input wire logic lad_oe,
  // Bus pins
  output logic lclk_pin,
  output logic lreset_n_pin,
  output logic lframe_n_pin,
  output logic [3:0] lad_in
);
  logic [2:0] div = 3'h0;
  logic [3:0] hlad = 4'hf;
  logic hoe = 1'b0;
  logic oe_q;
  logic [3:0] res_wc;
  logic [3:0] res_sy;
  logic [7:0] res_rd;
  int res_nw;
  int res_dv;
  event res_ev;

  // ----------------------------------------------------------------------
  // Bus clock and shared lines
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    div <= div + 3'h1;
  end
  assign lclk_pin = div[2];
  // Pull-ups hold idle lines high; two drivers at once read as unknown
  assign lad_in = (lad_oe & hoe) ? 4'hx :
                  lad_oe ? lad_out : hoe ? hlad : 4'hf;

  initial begin
    lframe_n_pin = 1'b1;
    lreset_n_pin = 1'b0;
    repeat (4000) @(posedge clk_sys);
    lreset_n_pin <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // One bus clock: drive at the falling edge, sample at the rising edge
  // ----------------------------------------------------------------------
  task automatic bus(input logic [3:0] nib, input logic fr,
                     input logic oe, output logic [3:0] got);
    @(posedge clk_sys iff div == 3'h7);
    hlad <= nib;
    hoe <= oe;
    lframe_n_pin <= fr;
    @(posedge clk_sys iff div == 3'h3);
    got = lad_in;
    oe_q = lad_oe;
  endtask

  // ----------------------------------------------------------------------
  // Whole cycle with sync counting and abort
  // ----------------------------------------------------------------------
  task automatic run(input logic [3:0] st, input logic [3:0] ct,
                     input logic [15:0] ad, input logic [7:0] wd,
                     input int abort_at);
    logic [3:0] g;
    logic [3:0] nibs[$];
    int k;
    nibs = '{st, ct};
    if (ct[3]) begin
      nibs.push_back({1'b0, ad[2:0]});
      nibs.push_back({2'b00, ad[5:4]});
    end else begin
      for (int j = 3; j >= 0; j--) nibs.push_back(ad[j*4 +: 4]);
    end
    if (ct[3] ^ ct[1]) begin
      nibs.push_back(wd[3:0]);
      nibs.push_back(wd[7:4]);
    end
    nibs.push_back(4'hf);
    foreach (nibs[i]) bus(nibs[i], i != 0, 1'b1, g);
    bus(4'hf, 1'b1, 1'b0, g);
    res_wc = 4'hf;
    res_nw = 0;
    res_sy = 4'hf;
    res_rd = 8'hff;
    res_dv = 0;
    k = 0;
    while (k < 3 && res_sy === 4'hf && res_nw < 400 &&
           !(abort_at != 0 && res_nw == abort_at)) begin
      bus(4'hf, 1'b1, 1'b0, g);
      if (g === 4'h5 || g === 4'h6) begin
        res_wc = (res_nw == 0 || res_wc === g) ? g : 4'hx;
        res_nw++;
        k = 0;
      end else if (g === 4'hf) begin
        k++;
      end else begin
        res_sy = g;
      end
    end
    if (res_sy === 4'hf) begin
      bus(4'hf, 1'b0, 1'b0, g);
      bus(4'hf, 1'b0, 1'b0, g);
      res_sy = g;
    end else if (!(ct[3] ^ ct[1])) begin
      bus(4'hf, 1'b1, 1'b0, g);
      res_rd[3:0] = g;
      res_dv = int'(oe_q);
      bus(4'hf, 1'b1, 1'b0, g);
      res_rd[7:4] = g;
      res_dv = res_dv + int'(oe_q);
    end
    bus(4'hf, 1'b1, 1'b0, g);
    bus(4'hf, 1'b1, 1'b0, g);
    ->res_ev;
  endtask
endmodule

/* File: sim/test_lpc_target_sync_wait_logic.sv */
// Self-checking bench for the bus target's sync and wait logic.
// Assumes the host model drives the bus pins, this bench the user side.
`timescale 1ns/1ps

module test_lpc_target_sync_wait_logic;
  typedef struct packed {
    logic [3:0] wc;
    logic [8:0] nw;
    logic [3:0] sy;
    logic [1:0] dv;
    logic ck;
    logic [7:0] rd;
  } lpcts_bus_res_t;
  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] key;
    logic [7:0] wd;
  } lpcts_acc_res_t;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic lclk_pin, lreset_n_pin, lframe_n_pin, lad_oe, ldrq_n;
  logic [3:0] lad_in, lad_out;
  logic acc_req, acc_write, acc_dma, err_v;
  logic [15:0] acc_addr;
  logic [2:0] acc_chan;
  logic [7:0] acc_wdata, rd_v;
  logic [7:0] acc_rdata = 8'h00;
  logic acc_done = 1'b0;
  logic acc_err = 1'b0;
  logic dma_req = 1'b0;
  int dly_v, n_mismatch = 0, checked = 0;
  lpcts_bus_res_t exp_bus[$];
  lpcts_acc_res_t exp_acc[$];

  always #12.5 clk_sys = ~clk_sys;

  lpcts_target DUT (.clk_sys(clk_sys), .rst(rst), .lclk_pin(lclk_pin),
    .lreset_n_pin(lreset_n_pin), .lframe_n_pin(lframe_n_pin),
    .lad_in(lad_in), .lad_out(lad_out), .lad_oe(lad_oe), .ldrq_n(ldrq_n),
    .acc_req(acc_req), .acc_write(acc_write), .acc_dma(acc_dma),
    .acc_addr(acc_addr), .acc_chan(acc_chan), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_err(acc_err), .acc_rdata(acc_rdata),
    .dma_req(dma_req));

  lpcts_host_model host (.clk_sys(clk_sys), .lad_out(lad_out),
    .lad_oe(lad_oe), .lclk_pin(lclk_pin), .lreset_n_pin(lreset_n_pin),
    .lframe_n_pin(lframe_n_pin), .lad_in(lad_in));

  // ----------------------------------------------------------------------
  // Comparison and verdict
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_bus(input lpcts_bus_res_t e);
    check("wait code", e.wc, host.res_wc);
    check("wait count", e.nw, host.res_nw[15:0]);
    check("sync code", e.sy, host.res_sy);
    if (e.ck) check("data drive", e.dv, host.res_dv[15:0]);
    if (e.ck && e.sy === 4'h0) check("read data", e.rd, host.res_rd);
  endtask

  task automatic cmp_acc(input lpcts_acc_res_t e);
    check("access kind", e.kind, {acc_write, acc_dma});
    check("access target", e.key,
      e.kind[0] ? {13'h0, acc_chan} : acc_addr);
    if (e.kind[1] ^ e.kind[0]) check("write data", e.wd, acc_wdata);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchers and user-side responder
  // ----------------------------------------------------------------------
  initial forever begin
    @(host.res_ev);
    if (exp_bus.size() == 0) check("bus result", 16'h0, 16'h1);
    else cmp_bus(exp_bus.pop_front());
  end

  always @(posedge clk_sys) begin
    if (acc_req === 1'b1) begin
      if (exp_acc.size() == 0) check("unexpected access", 16'h0, 16'h1);
      else cmp_acc(exp_acc.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    if (acc_req === 1'b1 && dly_v >= 0) begin
      repeat (dly_v) @(posedge clk_sys);
      acc_done <= 1'b1;
      acc_err <= err_v;
      acc_rdata <= rd_v;
      @(posedge clk_sys);
      acc_done <= 1'b0;
    end
  end

  // Notes the expected outcome, then has the host run the cycle
  task automatic cy(input logic [3:0] st, input logic [3:0] ct,
      input logic [15:0] ad, input int dly, input logic err,
      input logic [3:0] wc, input int nw, input logic [3:0] sy,
      input logic acc, input int abort_at);
    logic [7:0] wd;
    logic td;
    wd = 8'($urandom);
    rd_v = 8'($urandom);
    dly_v = dly;
    err_v = err;
    td = !(ct[3] ^ ct[1]) && sy !== 4'hf;
    exp_bus.push_back('{wc, 9'(nw), sy, td ? 2'h2 : 2'h0, td, rd_v});
    if (acc) exp_acc.push_back('{{ct[1], ct[3]},
                                 ct[3] ? {13'h0, ad[2:0]} : ad, wd});
    host.run(st, ct, ad, wd, abort_at);
    repeat (16) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int d;
    logic [15:0] ad;
    void'($urandom(32'hbc83));
    dma_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (40) @(posedge clk_sys);
    check("request in reset", 16'h1, ldrq_n);
    check("drive in reset", 16'h0, lad_oe);
    wait (lreset_n_pin === 1'b1);
    repeat (16) @(posedge clk_sys);
    check("request level", 16'h0, ldrq_n);
    dma_req <= 1'b0;
    ad = 16'($urandom_range(7));
    for (int s = 1; s < 16; s++) begin
      cy(4'(s), 4'h0, ad, 0, 1'b0, 4'hf, 0, 4'hf, 1'b0, 0);
    end
    cy(4'h0, 4'h4, ad, 0, 1'b0, 4'hf, 0, 4'hf, 1'b0, 0);
    cy(4'h0, 4'h0, 16'h0100, 0, 1'b0, 4'hf, 0, 4'hf, 1'b0, 0);
    cy(4'h0, 4'h8, 16'h0001, 0, 1'b0, 4'hf, 0, 4'hf, 1'b0, 0);
    cy(4'h0, 4'h8, 16'h0010, 0, 1'b0, 4'hf, 0, 4'hf, 1'b0, 0);
    cy(4'h0, 4'h0, ad, -1, 1'b0, 4'h6, 2, 4'hf, 1'b1, 2);
    for (int i = 0; i < 2; i++) begin
      d = $urandom_range(7);
      ad = 16'($urandom_range(7));
      cy(4'h0, 4'h0, ad, d, 1'b0, 4'h6, 3, 4'h0, 1'b1, 0);
      cy(4'h0, 4'h3, ad, d, 1'b0, 4'h6, 2, 4'h0, 1'b1, 0);
      cy(4'h0, 4'h8, 16'h0, d, 1'b0, 4'h5, 3, 4'h0, 1'b1, 0);
      cy(4'h0, 4'hb, 16'h0, d, 1'b0, 4'h5, 4, 4'h0, 1'b1, 0);
    end
    cy(4'h0, 4'hb, 16'h0, 1, 1'b1, 4'h5, 1, 4'ha, 1'b1, 0);
    cy(4'h0, 4'h3, ad, 1, 1'b1, 4'h6, 1, 4'ha, 1'b1, 0);
    cy(4'h0, 4'h8, 16'h0, -1, 1'b0, 4'h5, 7, 4'ha, 1'b1, 0);
    cy(4'h0, 4'h0, ad, -1, 1'b0, 4'h6, 329, 4'ha, 1'b1, 0);
    give_verdict();
  end

  // Whole run is about 11000 clocks; this allows over three times that
  initial begin
    #1ms;
    n_mismatch++;
    give_verdict();
  end
endmodule
